// File: design/cmre_defs.svh
// Purpose: offsets, field positions, reset values and sizes of the message RAM block
// Assumes: byte addresses on a 12-bit AXI4-Lite window
// Notes: RAM window occupies the upper half of the address space
`ifndef CMRE_DEFS_SVH
`define CMRE_DEFS_SVH
`define CMRE_OFF_CTRL 12'h000
`define CMRE_OFF_ECC_CTRL 12'h004
`define CMRE_OFF_ECC_STAT 12'h008
`define CMRE_OFF_MASK 12'h00C
`define CMRE_OFF_FILTER 12'h010
`define CMRE_OFF_FIFO_SEL 12'h014
`define CMRE_OFF_FIFO_CFG 12'h018
`define CMRE_OFF_USER_ADDR 12'h01C
`define CMRE_OFF_TXQ_CFG 12'h020
`define CMRE_RAM_BASE 12'h800
`define CMRE_CTRL_CFG_MODE 0
`define CMRE_CTRL_EVT_STORE 1
`define CMRE_CTRL_TXQ_EN 2
`define CMRE_CTRL_DATA_FILT 3
`define CMRE_CTRL_FLT_EN 4
`define CMRE_ECC_EN_BIT 0
`define CMRE_PAR_LSB 8
`define CMRE_STAT_SEC 0
`define CMRE_STAT_DED 1
`define CMRE_FCFG_PL_LSB 8
`define CMRE_TXQ_CNT_LSB 8
`define CMRE_TXQ_PL_LSB 16
`define CMRE_MASK_WMASK 32'h7FFFFFFF
`define CMRE_MASK_RST 32'h00000000
`define CMRE_HDR_BYTES 16'h0008
`define CMRE_TEF_OBJ_BYTES 16'h0008
`define CMRE_RESP_OKAY 2'h0
`define CMRE_RESP_SLVERR 2'h2
`define CMRE_KIND_T0 2'h1
`define CMRE_KIND_T1 2'h2
`define CMRE_KIND_DATA 2'h3
`endif

// File: design/cmre_pkg.sv
// Purpose: types shared by the message RAM block
// Assumes: nothing beyond the defs header
// Notes: all module state except the RAM array and its read register travels as one packed struct
package cmre_pkg;
   typedef enum logic [1:0] {st_idle, st_wresp, st_rram, st_rresp} cmre_axi_st_t;
   typedef struct packed {
      logic unused;
      logic id_type_match_enable;
      logic std_id_bit12_mask;
      logic [17:0] ext_id_mask;
      logic [10:0] std_id_mask;
   } cmre_mask_t;
   typedef struct packed {
      logic unused;
      logic filter_ext_id_select;
      logic std_id_bit12;
      logic [17:0] extended_id;
      logic [10:0] standard_id;
   } cmre_filter_t;
   typedef struct packed {
      logic [1:0] unused;
      logic std_id_bit12;
      logic [17:0] extended_id;
      logic [10:0] standard_id;
   } cmre_tx_t0_t;
   typedef struct packed {
      logic [15:0] unused;
      logic [6:0] tx_sequence_tag;
      logic esi;
      logic fdf;
      logic brs;
      logic rtr;
      logic ide;
      logic [3:0] dlc;
   } cmre_tx_t1_t;
   typedef struct packed {
      logic ide;
      logic std_id_bit12;
      logic [10:0] standard_id;
      logic [17:0] extended_id;
      logic [17:0] data_bits;
   } cmre_rx_frame_t;
   typedef logic [3:0][7:0] cmre_bytes_t;
   typedef struct packed {
      cmre_axi_st_t axi;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [11:0] rd_addr;
      logic config_mode;
      logic event_fifo_store_enable;
      logic tx_queue_enable;
      logic data_filter_mode;
      logic filter_enable;
      logic ecc_enable;
      logic [6:0] parity;
      logic err_single;
      logic err_double;
      cmre_mask_t mask;
      cmre_filter_t filter;
      logic [4:0] fifo_sel;
      logic [4:0] tef_cnt;
      logic [4:0] txq_cnt;
      logic [2:0] txq_pl;
      logic [31:1][4:0] fifo_cnt;
      logic [31:1][2:0] fifo_pl;
      logic [31:1][4:0] fifo_ptr;
      logic eng_rd_pend;
      logic [1:0] eng_kind;
      logic eng_rvalid;
      logic [31:0] eng_rdata;
      logic accept;
      logic accept_valid;
      cmre_tx_t0_t tx_t0;
      cmre_tx_t1_t tx_t1;
      cmre_bytes_t tx_bytes;
   } cmre_state_t;
endpackage

// File: design/cmre_ecc.sv
// Purpose: SEC/DED codec for one 32-bit RAM word with seven check bits
// Assumes: stored word is {check[6:0], data[31:0]}
// Notes: purely combinational; the caller registers around it
`timescale 1ns/1ps
module cmre_ecc (
   input wire logic ecc_enable,
   input wire logic [6:0] parity_in,
   input wire logic [31:0] wr_data,
   output logic [6:0] wr_check,
   input wire logic [38:0] rd_word,
   output logic [31:0] rd_data,
   output logic rd_single,
   output logic rd_double
);
   // hamming position of data bit idx, skipping power-of-two slots
   function automatic logic [5:0] data_pos(input int idx);
      int n;
      logic [5:0] pos;
      n = 0;
      pos = 6'h00;
      for (int q = 3; q < 39; q++) begin
         if ((q & (q - 1)) != 0) begin
            if (n == idx) begin
               pos = 6'(q);
            end
            n++;
         end
      end
      return pos;
   endfunction

   function automatic logic [5:0] syndrome(input logic [31:0] d);
      logic [5:0] s;
      logic [5:0] p;
      s = 6'h00;
      for (int i = 0; i < 32; i++) begin
         p = data_pos(i);
         for (int k = 0; k < 6; k++) begin
            if (p[k]) begin
               s[k] = s[k] ^ d[i];
            end
         end
      end
      return s;
   endfunction

   logic [5:0] enc_s;
   logic [5:0] syn;
   logic overall;

   always_comb begin
      enc_s = syndrome(wr_data);
      // test path: software parity lets a self-test plant known errors
      wr_check = ecc_enable ? {^{wr_data, enc_s}, enc_s} : parity_in; // see RQ11 see RQ13 see RQ14
   end

   always_comb begin
      syn = syndrome(rd_word[31:0]) ^ rd_word[37:32];
      overall = ^rd_word;
      rd_data = rd_word[31:0]; // see RQ13
      rd_single = ecc_enable && overall; // see RQ15
      rd_double = ecc_enable && !overall && (syn != 6'h00); // see RQ15
      if (rd_single) begin
         for (int i = 0; i < 32; i++) begin
            if (data_pos(i) == syn) begin
               rd_data[i] = !rd_word[i]; // see RQ12
            end
         end
      end
   end
endmodule

// File: design/cmre_top.sv
// Purpose: message RAM with SEC/DED, object allocation, acceptance mask and tx object fields
// Assumes: AXI4-Lite slave on aclk; engine port has priority on the RAM
// Notes: RAM writes from AXI need all four strobes; partial writes get SLVERR
// How it works
// RQ1: mask type bit set accepts only frames whose ID type equals filter select.
// RQ2: mask word: bit29 std bit12, bits28-11 ext mask, bits10-0 std mask.
// RQ3: data filtering mode applies ext mask to first 18 data bits.
// RQ4: mask bits read/write, reset to zero; bit 31 reads zero.
// RQ5: 2 KB internal RAM holds all message objects.
// RQ6: tx format for queue/tx FIFOs, rx format for rx, own event format.
// RQ7: object counts and payload sizes configurable per queue and FIFO.
// RQ8: object configuration changes only while in configuration mode.
// RQ9: allocation order: event objects, queue objects, then FIFO 1 to 31.
// RQ10: per-FIFO user address reports next object RAM address.
// RQ11: seven check bits stored beside each 32-bit word.
// RQ12: with ECC enabled every write encoded, every read decoded.
// RQ13: ECC off: store software parity, return data unchanged.
// RQ14: encoder computes check bits from written word.
// RQ15: decoder corrects single errors, flags double errors, strips checks.
// RQ16: tx word 0: bits 31-30 unused, std ID 10-0, ext ID 28-11.
// RQ17: tx word 0 bit 29 extends standard ID to 12 bits.
// RQ18: tx word 1: sequence tag 15-9, ESI, FDF, BRS, RTR, IDE, DLC.
// RQ19: with type match, select 1 accepts extended, 0 standard only.
// RQ20: payload bytes packed from word 2, byte 0 in bits 7-0.
// RQ21: corrected single and detected double errors raise host-visible flags.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "cmre_defs.svh"
module cmre_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic eng_req,
   input wire logic eng_we,
   input wire logic [8:0] eng_addr,
   input wire logic [31:0] eng_wdata,
   input wire logic [1:0] eng_kind,
   output logic [31:0] eng_rdata,
   output logic eng_rvalid,
   input wire logic [31:1] fifo_adv,
   input wire cmre_pkg::cmre_rx_frame_t rx_frame,
   input wire logic rx_check,
   output logic accept,
   output logic accept_valid,
   output cmre_pkg::cmre_tx_t0_t tx_t0,
   output cmre_pkg::cmre_tx_t1_t tx_t1,
   output cmre_pkg::cmre_bytes_t tx_bytes,
   output logic ecc_single,
   output logic ecc_double
);
   cmre_pkg::cmre_state_t st_ff;
   cmre_pkg::cmre_state_t nxt_st;
   logic [38:0] ram_mem [0:511]; // see RQ5
   logic [38:0] ram_q_ff;
   logic ram_we;
   logic ram_re;
   logic [8:0] ram_addr;
   logic [31:0] ram_wdata;
   logic [6:0] enc_check;
   logic [31:0] dec_data;
   logic dec_single;
   logic dec_double;
   logic dec_use;
   logic aw_ram;
   logic ar_ram;
   logic aw_take;
   logic ar_take;
   logic [31:0] reg_rd;
   logic rd_ok;
   logic [31:0] wr_val;
   logic hit;
   logic [15:0] fifo_base [1:32];
   logic [15:0] fifo_size [1:31];
   logic [15:0] txq_size;
   cmre_pkg::cmre_bytes_t dec_bytes;

   function automatic logic [15:0] pl_bytes(input logic [2:0] code);
      unique case (code)
         3'h0: pl_bytes = 16'h0008;
         3'h1: pl_bytes = 16'h000C;
         3'h2: pl_bytes = 16'h0010;
         3'h3: pl_bytes = 16'h0014;
         3'h4: pl_bytes = 16'h0018;
         3'h5: pl_bytes = 16'h0020;
         3'h6: pl_bytes = 16'h0030;
         3'h7: pl_bytes = 16'h0040;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            merge[8*b +: 8] = d[8*b +: 8];
         end
      end
   endfunction

   cmre_ecc u_ecc (
      .ecc_enable(st_ff.ecc_enable),
      .parity_in(st_ff.parity),
      .wr_data(ram_wdata),
      .wr_check(enc_check),
      .rd_word(ram_q_ff),
      .rd_data(dec_data),
      .rd_single(dec_single),
      .rd_double(dec_double)
   );

   // engine never waits; AXI RAM access yields to it
   assign aw_ram = awaddr[11];
   assign ar_ram = araddr[11];
   assign aw_take = awvalid && wvalid && st_ff.axi == cmre_pkg::st_idle && !(aw_ram && eng_req);
   assign ar_take = arvalid && st_ff.axi == cmre_pkg::st_idle && !(awvalid && wvalid) && !(ar_ram && eng_req);
   assign awready = aw_take;
   assign wready = aw_take;
   assign arready = ar_take;
   assign ram_we = eng_req ? eng_we : (aw_take && aw_ram && wstrb == 4'hF);
   assign ram_re = eng_req ? !eng_we : (ar_take && ar_ram);
   assign ram_addr = eng_req ? eng_addr : (aw_take ? awaddr[10:2] : araddr[10:2]);
   assign ram_wdata = eng_req ? eng_wdata : wdata;
   assign dec_use = st_ff.eng_rd_pend || st_ff.axi == cmre_pkg::st_rram;
   assign wr_val = merge(reg_rd, wdata, wstrb);

   always_ff @(posedge aclk) begin
      if (ram_we) begin
         ram_mem[ram_addr] <= {enc_check, ram_wdata}; // see RQ12 see RQ14
      end
      if (ram_re) begin
         ram_q_ff <= ram_mem[ram_addr];
      end
   end

   // allocation chain: events, then queue, then FIFOs in order
   assign txq_size = `CMRE_HDR_BYTES + pl_bytes(st_ff.txq_pl);
   assign fifo_base[1] = (st_ff.event_fifo_store_enable ? (16'(st_ff.tef_cnt) + 16'h0001) * `CMRE_TEF_OBJ_BYTES : 16'h0000)
      + (st_ff.tx_queue_enable ? (16'(st_ff.txq_cnt) + 16'h0001) * txq_size : 16'h0000); // see RQ9
   genvar f;
   generate
      for (f = 1; f < 32; f++) begin : g_fifo
         assign fifo_size[f] = `CMRE_HDR_BYTES + pl_bytes(st_ff.fifo_pl[f]); // see RQ6 see RQ7
         assign fifo_base[f+1] = fifo_base[f] + (16'(st_ff.fifo_cnt[f]) + 16'h0001) * fifo_size[f]; // see RQ9
      end
      for (f = 0; f < 4; f++) begin : g_byte
         assign dec_bytes[f] = dec_data[8*f +: 8]; // see RQ20
      end
   endgenerate

   // acceptance match against the single mask/filter pair
   always_comb begin
      logic [17:0] ext_src;
      logic ext_ok;
      ext_src = st_ff.data_filter_mode ? rx_frame.data_bits : rx_frame.extended_id; // see RQ3
      ext_ok = !(rx_frame.ide || st_ff.data_filter_mode) || (((ext_src ^ st_ff.filter.extended_id)
         & st_ff.mask.ext_id_mask) == 18'h00000);
      hit = st_ff.filter_enable && ext_ok
         && (((rx_frame.standard_id ^ st_ff.filter.standard_id) & st_ff.mask.std_id_mask) == 11'h000)
         && !((rx_frame.std_id_bit12 ^ st_ff.filter.std_id_bit12) & st_ff.mask.std_id_bit12_mask)
         && (!st_ff.mask.id_type_match_enable || rx_frame.ide == st_ff.filter.filter_ext_id_select); // see RQ1 see RQ19
   end

   always_comb begin
      reg_rd = 32'h00000000;
      rd_ok = 1'b1;
      unique case (st_ff.axi == cmre_pkg::st_idle && aw_take ? awaddr : araddr)
         `CMRE_OFF_CTRL: reg_rd = {27'h0, st_ff.filter_enable, st_ff.data_filter_mode, st_ff.tx_queue_enable,
            st_ff.event_fifo_store_enable, st_ff.config_mode};
         `CMRE_OFF_ECC_CTRL: reg_rd = {17'h0, st_ff.parity, 7'h0, st_ff.ecc_enable};
         `CMRE_OFF_ECC_STAT: reg_rd = {30'h0, st_ff.err_double, st_ff.err_single}; // see RQ21
         `CMRE_OFF_MASK: reg_rd = {1'b0, st_ff.mask[30:0]}; // see RQ4
         `CMRE_OFF_FILTER: reg_rd = {1'b0, st_ff.filter[30:0]};
         `CMRE_OFF_FIFO_SEL: reg_rd = {27'h0, st_ff.fifo_sel};
         `CMRE_OFF_FIFO_CFG: reg_rd = (st_ff.fifo_sel == 5'h00) ? 32'h00000000 :
            {21'h0, st_ff.fifo_pl[st_ff.fifo_sel], 3'h0, st_ff.fifo_cnt[st_ff.fifo_sel]};
         `CMRE_OFF_USER_ADDR: reg_rd = (st_ff.fifo_sel == 5'h00) ? 32'h00000000 :
            {20'h0, `CMRE_RAM_BASE} + {16'h0, fifo_base[st_ff.fifo_sel]}
            + {16'h0, 16'(st_ff.fifo_ptr[st_ff.fifo_sel] * fifo_size[st_ff.fifo_sel])}; // see RQ10
         `CMRE_OFF_TXQ_CFG: reg_rd = {13'h0, st_ff.txq_pl, 3'h0, st_ff.txq_cnt, 3'h0, st_ff.tef_cnt};
         default: rd_ok = 1'b0;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.eng_rvalid = st_ff.eng_rd_pend;
      nxt_st.eng_rd_pend = eng_req && !eng_we;
      nxt_st.eng_kind = eng_kind;
      if (st_ff.eng_rd_pend) begin
         nxt_st.eng_rdata = dec_data;
         if (st_ff.eng_kind == `CMRE_KIND_T0) begin
            nxt_st.tx_t0 = dec_data; // see RQ16 see RQ17
         end
         if (st_ff.eng_kind == `CMRE_KIND_T1) begin
            nxt_st.tx_t1 = dec_data; // see RQ18
         end
         if (st_ff.eng_kind == `CMRE_KIND_DATA) begin
            nxt_st.tx_bytes = dec_bytes; // see RQ20
         end
      end
      for (int i = 1; i < 32; i++) begin
         if (st_ff.config_mode) begin
            nxt_st.fifo_ptr[i] = 5'h00;
         end else if (fifo_adv[i]) begin
            nxt_st.fifo_ptr[i] = (st_ff.fifo_ptr[i] == st_ff.fifo_cnt[i]) ? 5'h00 : st_ff.fifo_ptr[i] + 5'h01;
         end
      end
      nxt_st.accept_valid = rx_check;
      if (rx_check) begin
         nxt_st.accept = hit;
      end
      unique case (st_ff.axi)
         cmre_pkg::st_idle: begin
            if (aw_take) begin
               nxt_st.bresp = `CMRE_RESP_OKAY;
               nxt_st.axi = cmre_pkg::st_wresp;
               if (aw_ram) begin
                  if (wstrb != 4'hF) begin
                     nxt_st.bresp = `CMRE_RESP_SLVERR;
                  end
               end else begin
                  unique case (awaddr)
                     `CMRE_OFF_CTRL: begin
                        nxt_st.config_mode = wr_val[`CMRE_CTRL_CFG_MODE];
                        nxt_st.data_filter_mode = wr_val[`CMRE_CTRL_DATA_FILT];
                        nxt_st.filter_enable = wr_val[`CMRE_CTRL_FLT_EN];
                        if (st_ff.config_mode) begin // see RQ8
                           nxt_st.event_fifo_store_enable = wr_val[`CMRE_CTRL_EVT_STORE];
                           nxt_st.tx_queue_enable = wr_val[`CMRE_CTRL_TXQ_EN];
                        end
                     end
                     `CMRE_OFF_ECC_CTRL: begin
                        nxt_st.ecc_enable = wr_val[`CMRE_ECC_EN_BIT];
                        nxt_st.parity = wr_val[`CMRE_PAR_LSB +: 7];
                     end
                     `CMRE_OFF_ECC_STAT: begin
                        nxt_st.err_single = st_ff.err_single && !(wstrb[0] && wdata[`CMRE_STAT_SEC]);
                        nxt_st.err_double = st_ff.err_double && !(wstrb[0] && wdata[`CMRE_STAT_DED]);
                     end
                     `CMRE_OFF_MASK: nxt_st.mask = wr_val & `CMRE_MASK_WMASK; // see RQ2 see RQ4
                     `CMRE_OFF_FILTER: nxt_st.filter = wr_val & `CMRE_MASK_WMASK;
                     `CMRE_OFF_FIFO_SEL: nxt_st.fifo_sel = wr_val[4:0];
                     `CMRE_OFF_FIFO_CFG: begin
                        if (st_ff.config_mode && st_ff.fifo_sel != 5'h00) begin // see RQ7 see RQ8
                           nxt_st.fifo_cnt[st_ff.fifo_sel] = wr_val[4:0];
                           nxt_st.fifo_pl[st_ff.fifo_sel] = wr_val[`CMRE_FCFG_PL_LSB +: 3];
                        end
                     end
                     `CMRE_OFF_TXQ_CFG: begin
                        if (st_ff.config_mode) begin // see RQ7 see RQ8
                           nxt_st.tef_cnt = wr_val[4:0];
                           nxt_st.txq_cnt = wr_val[`CMRE_TXQ_CNT_LSB +: 5];
                           nxt_st.txq_pl = wr_val[`CMRE_TXQ_PL_LSB +: 3];
                        end
                     end
                     `CMRE_OFF_USER_ADDR: nxt_st.bresp = `CMRE_RESP_OKAY;
                     default: nxt_st.bresp = `CMRE_RESP_SLVERR;
                  endcase
               end
            end else if (ar_take) begin
               nxt_st.rd_addr = araddr;
               nxt_st.rresp = (ar_ram || rd_ok) ? `CMRE_RESP_OKAY : `CMRE_RESP_SLVERR;
               nxt_st.rdata = reg_rd;
               nxt_st.axi = ar_ram ? cmre_pkg::st_rram : cmre_pkg::st_rresp;
            end
         end
         cmre_pkg::st_wresp: if (bready) nxt_st.axi = cmre_pkg::st_idle;
         cmre_pkg::st_rram: begin
            nxt_st.rdata = dec_data; // see RQ15
            nxt_st.axi = cmre_pkg::st_rresp;
         end
         cmre_pkg::st_rresp: if (rready) nxt_st.axi = cmre_pkg::st_idle;
      endcase
      // set after clear so a same-cycle error is never lost
      if (dec_use && dec_single) begin
         nxt_st.err_single = 1'b1; // see RQ21
      end
      if (dec_use && dec_double) begin
         nxt_st.err_double = 1'b1; // see RQ21
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
         st_ff.config_mode <= 1'b1;
         st_ff.mask <= `CMRE_MASK_RST; // see RQ4
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign bvalid = st_ff.axi == cmre_pkg::st_wresp;
   assign bresp = st_ff.bresp;
   assign rvalid = st_ff.axi == cmre_pkg::st_rresp;
   assign rdata = st_ff.rdata;
   assign rresp = st_ff.rresp;
   assign eng_rdata = st_ff.eng_rdata;
   assign eng_rvalid = st_ff.eng_rvalid;
   assign accept = st_ff.accept;
   assign accept_valid = st_ff.accept_valid;
   assign tx_t0 = st_ff.tx_t0;
   assign tx_t1 = st_ff.tx_t1;
   assign tx_bytes = st_ff.tx_bytes;
   assign ecc_single = st_ff.err_single;
   assign ecc_double = st_ff.err_double;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_mask_reset_zero: assert property (disable iff (1'b0) !aresetn |=> st_ff.mask == 32'h00000000) // see RQ4
      else $error("mask not zero after reset");
   a_mask_top_zero: assert property (rvalid && st_ff.rd_addr == `CMRE_OFF_MASK |-> !rdata[31]) // see RQ4
      else $error("mask bit 31 read as one");
   a_type_match: assert property (rx_check && st_ff.mask.id_type_match_enable // see RQ1
      && rx_frame.ide != st_ff.filter.filter_ext_id_select |=> accept_valid && !accept)
      else $error("frame of wrong id type accepted");
   a_ext_select: assert property (rx_check && st_ff.mask.id_type_match_enable && st_ff.filter_enable // see RQ19
      && st_ff.mask == 32'h40000000 && rx_frame.ide == st_ff.filter.filter_ext_id_select |=> accept)
      else $error("matching id type refused");
   a_cfg_lock: assert property (aw_take && !st_ff.config_mode // see RQ8
      && (awaddr == `CMRE_OFF_FIFO_CFG || awaddr == `CMRE_OFF_TXQ_CFG) |=> $stable(st_ff.fifo_cnt)
      && $stable(st_ff.txq_cnt) && $stable(st_ff.tef_cnt))
      else $error("allocation changed outside configuration mode");
   a_alloc_empty: assert property (!st_ff.event_fifo_store_enable && !st_ff.tx_queue_enable // see RQ9
      |-> fifo_base[1] == 16'h0000)
      else $error("fifo 1 not at start of ram");
   a_ecc_store: assert property (ram_we && st_ff.ecc_enable // see RQ14
      |=> ram_mem[$past(ram_addr)][31:0] == $past(ram_wdata) && ^ram_mem[$past(ram_addr)] == 1'b0)
      else $error("encoded word stored wrongly");
   a_parity_store: assert property (ram_we && !st_ff.ecc_enable // see RQ13
      |=> ram_mem[$past(ram_addr)][38:32] == $past(st_ff.parity))
      else $error("software parity not stored");
   a_raw_read: assert property (st_ff.eng_rd_pend && !st_ff.ecc_enable // see RQ13
      |=> eng_rvalid && eng_rdata == $past(ram_q_ff[31:0]))
      else $error("data altered with ecc off");
   a_ded_flag: assert property (dec_use && dec_double |=> ecc_double[*2]) // see RQ21
      else $error("double error not flagged");
   a_write_resp: assert property (aw_take |=> bvalid)
      else $error("write response missing");

   c_ecc_write: cover property (ram_we && st_ff.ecc_enable);
   c_single_fix: cover property (dec_use && dec_single);
   c_double_err: cover property (dec_use && dec_double);
   c_accept: cover property (accept_valid && accept);
endmodule

// File: bench/cmre_eng.sv
// Purpose: engine-side partner on the RAM port
// Assumes: each call starts just after a rising edge
// Notes: idle address and data lines carry inverted values so stale data cannot pass
`timescale 1ns/1ps
module cmre_eng (
   input wire logic aclk,
   output logic eng_req = 1'b0,
   output logic eng_we = 1'b0,
   output logic [8:0] eng_addr = 9'h0,
   output logic [31:0] eng_wdata = 32'h0,
   output logic [1:0] eng_kind = 2'h0,
   input wire logic eng_rvalid
);
   int n_late = 0;
   task automatic xfer(input logic we, input logic [8:0] a, input logic [31:0] v, input logic [1:0] k);
      int n = 0;
      {eng_req, eng_we, eng_addr, eng_wdata, eng_kind} <= {1'b1, we, a, v, k};
      @(posedge aclk);
      {eng_req, eng_addr, eng_wdata} <= {1'b0, ~a, ~v};
      do @(posedge aclk); while (!we && eng_rvalid !== 1'b1 && ++n < 8);
      if (!we && eng_rvalid !== 1'b1) n_late++;
   endtask
endmodule

// File: bench/cmre_top_test.sv
// Purpose: self-checking bench for the message RAM block
// Assumes: an all-zero word encodes to all-zero check bits
// Notes: faults are injected through the parity override with ECC off
`timescale 1ns/1ps
module cmre_top_test;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rx_check = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, eng_req, eng_we, eng_rvalid, accept, accept_valid;
   logic ecc_single, ecc_double;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, eng_wdata, eng_rdata, tx_t0, tx_t1, tx_bytes;
   logic [1:0] bresp, rresp, eng_kind;
   logic [8:0] eng_addr;
   cmre_pkg::cmre_rx_frame_t rx_frame = '0;
   logic [31:1] fifo_adv = '0;
   int n_errors = 0, n_checks = 0;
   cmre_top i_cmre_top (.*, .wstrb(4'hF), .bready(1'b1), .rready(1'b1));
   cmre_eng i_cmre_eng (.*);
   initial forever #10 aclk = ~aclk;
   task chk(input string s, input logic [33:0] e, input logic [33:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task give_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wait_hi(ref logic s);
      int n = 0;
      do @(posedge aclk); while (s !== 1'b1 && ++n < 50);
      chk("handshake", 34'h1, n < 50);
      if (n >= 50) give_verdict();
   endtask
   task wr(input logic [11:0] a, input logic [31:0] v);
      {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'b11};
      wait_hi(awready);
      {awaddr, wdata, awvalid, wvalid} <= {~a, ~v, 2'b00};
      wait_hi(bvalid);
      chk("bresp", 34'h0, bresp);
   endtask
   task rd(input string s, input logic [11:0] a, input logic [31:0] e);
      {araddr, arvalid} <= {a, 1'b1};
      wait_hi(arready);
      {araddr, arvalid} <= {~a, 1'b0};
      wait_hi(rvalid);
      chk(s, {(a == 12'h0FC) ? 2'h2 : 2'h0, e}, {rresp, rdata});
   endtask
   task flt(input logic i, input logic e);
      {rx_frame.ide, rx_check} <= {i, 1'b1};
      @(posedge aclk);
      rx_check <= 1'b0;
      @(posedge aclk);
      chk("accept", {e, 1'b1}, {accept, accept_valid});
   endtask
   task t_regs();
      rd("mask0", 12'h00C, 32'h0);
      wr(12'h00C, 32'hFFFFFFFF);
      rd("mask1", 12'h00C, 32'h7FFFFFFF);
      rd("hole", 12'h0FC, 32'h0);
      wr(12'h000, 32'h7);
      wr(12'h020, 32'h1);
      wr(12'h014, 32'h2);
      wr(12'h018, 32'h1);
      rd("uaddr", 12'h01C, 32'h830);
      wr(12'h000, 32'h6);
      fifo_adv[2] <= 1'b1;
      @(posedge aclk);
      fifo_adv[2] <= 1'b0;
      wr(12'h020, 32'h0);
      rd("uaddr1", 12'h01C, 32'h840);
      wr(12'h000, 32'h11);
      wr(12'h010, 32'h40000000);
      wr(12'h00C, 32'h40000000);
      flt(1'b1, 1'b1);
      flt(1'b0, 1'b0);
      wr(12'h000, 32'h19);
      wr(12'h00C, 32'h1FFFF800);
      rx_frame.data_bits <= 18'h1;
      flt(1'b0, 1'b0);
      rx_frame.data_bits <= 18'h0;
      flt(1'b0, 1'b1);
   endtask
   task t_ram();
      wr(12'h004, 32'h100);
      wr(12'h820, 32'h0);
      rd("raw", 12'h820, 32'h0);
      i_cmre_eng.xfer(1'b1, 9'h00C, 32'h1234ABCD, 2'h0);
      i_cmre_eng.xfer(1'b0, 9'h00C, 32'h0, 2'h0);
      chk("eng raw", 34'h1234ABCD, eng_rdata);
      wr(12'h004, 32'h300);
      wr(12'h824, 32'h0);
      wr(12'h004, 32'h0);
      wr(12'h828, 32'h1);
      wr(12'h004, 32'h1);
      rd("fixed", 12'h820, 32'h0);
      rd("fix data", 12'h828, 32'h0);
      i_cmre_eng.xfer(1'b0, 9'h009, 32'h0, 2'h0);
      chk("flags", 34'h3, {ecc_double, ecc_single});
      i_cmre_eng.xfer(1'b1, 9'h004, 32'hA5A50F0F, 2'h0);
      i_cmre_eng.xfer(1'b1, 9'h005, 32'h2ABCD123, 2'h0);
      i_cmre_eng.xfer(1'b1, 9'h006, 32'hB5A7, 2'h0);
      i_cmre_eng.xfer(1'b0, 9'h005, 32'h0, 2'h1);
      chk("t0", 34'h2ABCD123, tx_t0[29:0]);
      i_cmre_eng.xfer(1'b0, 9'h006, 32'h0, 2'h2);
      chk("t1", 34'hB5A7, tx_t1[15:0]);
      i_cmre_eng.xfer(1'b0, 9'h004, 32'h0, 2'h3);
      chk("bytes", 34'hA50F, {tx_bytes[31:24], tx_bytes[7:0]});
   endtask
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_ram();
      chk("engine", 34'h0, i_cmre_eng.n_late);
      give_verdict();
   end
endmodule
